// ---- hdl/ntc_pkg.sv ----
package ntc_pkg;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_TS_LATCH     = 8'h04;
  localparam logic [7:0]  OFS_TS_CLEAR     = 8'h08;
  localparam logic [7:0]  OFS_TS_SNAP_LO   = 8'h0c;
  localparam logic [7:0]  OFS_TS_SNAP_HI   = 8'h10;
  localparam logic [7:0]  OFS_TS_RATE      = 8'h14;
  localparam logic [7:0]  OFS_KA_TMO       = 8'h18;
  localparam logic [7:0]  OFS_DISC_MAX     = 8'h1c;
  localparam logic [7:0]  OFS_MSG_TMO      = 8'h20;
  localparam logic [7:0]  OFS_MSG_RETRY    = 8'h24;
  localparam logic [7:0]  OFS_MSG_DEST_IP  = 8'h28;
  localparam logic [7:0]  OFS_MSG_HOST_PRT = 8'h2c;
  localparam logic [7:0]  OFS_MSG_SRC_PRT  = 8'h30;
  localparam logic [7:0]  OFS_STR_DEST_IP  = 8'h34;
  localparam logic [7:0]  OFS_STR_HOST_PRT = 8'h38;
  localparam logic [7:0]  OFS_STR_SRC_PRT  = 8'h3c;
  localparam logic [7:0]  OFS_STR_PKT      = 8'h40;
  localparam logic [7:0]  OFS_PKT_GAP      = 8'h44;
  localparam logic [7:0]  OFS_FRM_GAP      = 8'h48;
  localparam logic [7:0]  OFS_PRIV         = 8'h4c;
  localparam logic [7:0]  OFS_CTL_PORT     = 8'h50;
  localparam logic [7:0]  OFS_CTL_IP       = 8'h54;
  localparam logic [7:0]  OFS_STORED_IP    = 8'h58;
  localparam logic [7:0]  OFS_STORED_MASK  = 8'h5c;
  localparam logic [7:0]  OFS_STORED_GW    = 8'h60;
  localparam logic [7:0]  OFS_CUR_IP       = 8'h64;
  localparam logic [7:0]  OFS_CUR_MASK     = 8'h68;
  localparam logic [7:0]  OFS_CUR_GW       = 8'h6c;
  localparam logic [7:0]  OFS_IP_CFG_STATE = 8'h70;
  localparam logic [7:0]  OFS_DEV_INFO     = 8'h74;
  localparam logic [7:0]  OFS_PAYLOAD      = 8'h78;
  localparam logic [7:0]  OFS_LINK_RATE    = 8'h7c;
  localparam logic [7:0]  OFS_HW_ADDR_LO   = 8'h80;
  localparam logic [7:0]  OFS_HW_ADDR_HI   = 8'h84;

  // control register bit positions
  localparam int          CB_KA_OFF        = 0;
  localparam int          CB_PROBE         = 1;
  localparam int          CB_NO_FRAG       = 2;
  localparam int          CB_PIX_MSB       = 3;
  localparam int          CB_LLA           = 4;
  localparam int          CB_DHCP          = 5;
  localparam int          CB_STORED        = 6;

  // reset values and limits
  localparam logic [31:0] KA_TMO_RST       = 32'h0000_0bb8; // 3000 ms
  localparam logic [31:0] DISC_MAX_RST     = 32'h0000_0032; // 50 ms
  localparam logic [31:0] DISC_MAX_LIM     = 32'h0000_03e8; // 1000 ms
  localparam logic [31:0] MSG_TMO_RST      = 32'h0000_012c; // 300 ms
  localparam logic [31:0] MSG_RETRY_RST    = 32'h0000_0002;
  localparam logic [31:0] PKT_RST          = 32'h0000_05dc; // 1500 bytes
  localparam logic [31:0] PKT_MIN          = 32'h0000_0048; // 72 bytes
  localparam logic [31:0] PKT_MAX          = 32'h0000_3fec; // 16364 bytes
  localparam logic [15:0] LFSR_SEED        = 16'hace1;

  // timing
  localparam logic [31:0] CLK_HZ           = 32'h0131_2d00; // 20 MHz
  localparam logic [31:0] CLK_PERIOD_NS    = 32'h0000_0032; // 50 ns
  localparam logic [31:0] TS_RATE_HZ       = 32'h000f_4240; // 1 MHz
  localparam int          TS_DIV           = int'(CLK_HZ / TS_RATE_HZ);
  localparam logic [31:0] MS_NS            = 32'h000f_4240; // 1 ms in ns
  localparam int          MS_CYCLES        = int'(MS_NS / CLK_PERIOD_NS);

  // bus responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {
    MONITOR_ONLY_LEVEL   = 2'h0,
    SOLE_CONTROL_LEVEL   = 2'h1,
    SHARED_CONTROL_LEVEL = 2'h2
  } ntc_priv_t;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b01,
    MSG_WAIT = 2'b10
  } ntc_msg_t;

endpackage

// ---- hdl/ntc_top.sv ----
// What this block does
// - latch command copies the live timestamp counter into the snapshot
// - clear command restarts the timestamp counter from zero
// - snapshot is 64 bits wide and read-only
// - tick rate of the timestamp counter is readable in hertz
// - keepalive timeout in ms, full 32-bit range, resets to 3000
// - keepalive off flag stops heartbeat supervision
// - discovery reply delayed randomly up to a max of 0..1000 ms, default 50
// - message channel waits a writable timeout, default 300 ms, for ack
// - unacked message resent up to a writable retry count, default 2
// - host sets message destination ip and port; source port read-only
// - stream goes to host-set ip and port; own source port read-only
// - probe flag true makes the stream send a test packet
// - writable flag drives the no-fragment bit of stream packets
// - writable flag picks big or little endian pixel order
// - stream packet size in bytes follows the writable setting
// - writable idle gap inserted between stream packets
// - separate writable gap between frames, on top of the packet gap
// - host writes privilege; controller port and ip recorded, read-only
// - three address mode enables, stored ip/mask/gw, current values readable
// - register space endianness readable
// - image payload size and channel counts readable
// - link rate, interface count and hardware address readable
// - packet size accepts 72..16364 and resets to 1500
// - privilege encodes monitor only, sole control and shared control
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
module ntc_top
  import ntc_pkg::*;
#(
  parameter int          MS_CYC         = MS_CYCLES,
  parameter logic [15:0] MSG_SRC_PORT   = 16'hc000,
  parameter logic [15:0] STR_SRC_PORT   = 16'hc001,
  parameter logic [7:0]  MSG_CHAN_NUM   = 8'h01,
  parameter logic [7:0]  STR_CHAN_NUM   = 8'h01,
  parameter logic [7:0]  IFC_NUM        = 8'h01,
  parameter logic        REGSPACE_MSB   = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // device state shown to software
  input  wire logic [31:0] curIp,
  input  wire logic [31:0] curMask,
  input  wire logic [31:0] curGw,
  input  wire logic [31:0] ipCfgState,
  input  wire logic [31:0] imagePayloadBytes,
  input  wire logic [31:0] negotiatedRate,
  input  wire logic [47:0] hwNetAddress,
  // control channel events
  input  wire logic        ctrlOpen,
  input  wire logic [15:0] ctrlPortIn,
  input  wire logic [31:0] ctrlIpIn,
  input  wire logic        heartbeatSeen,
  input  wire logic        discoverReq,
  output logic             keepaliveLapse,
  output logic             discoverReplyGo,
  output logic [1:0]       controlPrivilege,
  // message channel
  input  wire logic        msgSent,
  input  wire logic        msgAck,
  output logic             msgResend,
  output logic             msgGiveUp,
  output logic [31:0]      msgChanDestIp,
  output logic [15:0]      msgChanHostPort,
  // stream channel
  input  wire logic        pktDone,
  input  wire logic        frameDone,
  output logic             streamHold,
  output logic [31:0]      streamDestIp,
  output logic [15:0]      streamHostPort,
  output logic [15:0]      streamPacketBytes,
  output logic             streamProbePacketEn,
  output logic             streamNoFrag,
  output logic             streamPixelMsbFirst,
  // address configuration
  output logic             linkLocalCfgEn,
  output logic             dynamicCfgEn,
  output logic             storedCfgEn,
  output logic [31:0]      storedIp,
  output logic [31:0]      storedMask,
  output logic [31:0]      storedGw
);

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // address decode shared by read and write paths
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_HW_ADDR_HI);
  endfunction

  logic [7:0]  awAddrQ;
  logic [3:0]  wStrbQ;
  logic        wrFire, keepaliveOff, tsTick, msTick, ctrlActive, discBusy;
  logic [15:0] tsPre, ctrlPort, lfsr;
  logic [26:0] discProd;
  logic [31:0] wDataQ, rdMux, kaTimeout, discMax, msgTimeout, msgRetry, pktGap, frmGap, msPre, ctrlIp;
  logic [31:0] kaCount, discCount, msgTimer, msgTries, candDisc, candPkt, candPriv;
  logic [32:0] gapCount, next_gapCount;
  logic [63:0] tsCount, tsSnap;
  ntc_msg_t    msgState;

  // both channels latched before the write commits; no stall on ordering
  assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write address, data and response channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddrQ       <= 8'h00;
      wDataQ        <= 32'h0000_0000;
      wStrbQ        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrQ       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataQ       <= s_axi_wdata;
        wStrbQ       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // bounded fields: an out-of-range write leaves the old value
  assign candDisc = merge(discMax, wDataQ, wStrbQ);
  assign candPkt  = merge({16'h0000, streamPacketBytes}, wDataQ, wStrbQ);
  assign candPriv = merge({30'h0, controlPrivilege}, wDataQ, wStrbQ);

  // software-writable configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keepaliveOff        <= 1'b0;
      streamProbePacketEn <= 1'b0;
      streamNoFrag        <= 1'b0;
      streamPixelMsbFirst <= 1'b0;
      linkLocalCfgEn      <= 1'b0;
      dynamicCfgEn        <= 1'b0;
      storedCfgEn         <= 1'b0;
      kaTimeout           <= KA_TMO_RST;
      discMax             <= DISC_MAX_RST;
      msgTimeout          <= MSG_TMO_RST;
      msgRetry            <= MSG_RETRY_RST;
      msgChanDestIp       <= 32'h0000_0000;
      msgChanHostPort     <= 16'h0000;
      streamDestIp        <= 32'h0000_0000;
      streamHostPort      <= 16'h0000;
      streamPacketBytes   <= PKT_RST[15:0];
      pktGap              <= 32'h0000_0000;
      frmGap              <= 32'h0000_0000;
      controlPrivilege    <= SOLE_CONTROL_LEVEL;
      storedIp            <= 32'h0000_0000;
      storedMask          <= 32'h0000_0000;
      storedGw            <= 32'h0000_0000;
    end else if (wrFire) begin
      case (awAddrQ)
        OFS_CTRL: if (wStrbQ[0]) begin
          keepaliveOff        <= wDataQ[CB_KA_OFF];
          streamProbePacketEn <= wDataQ[CB_PROBE];
          streamNoFrag        <= wDataQ[CB_NO_FRAG];
          streamPixelMsbFirst <= wDataQ[CB_PIX_MSB];
          linkLocalCfgEn      <= wDataQ[CB_LLA];
          dynamicCfgEn        <= wDataQ[CB_DHCP];
          storedCfgEn         <= wDataQ[CB_STORED];
        end
        OFS_KA_TMO:       kaTimeout <= merge(kaTimeout, wDataQ, wStrbQ);
        OFS_DISC_MAX:     if (candDisc <= DISC_MAX_LIM) discMax <= candDisc;
        OFS_MSG_TMO:      msgTimeout <= merge(msgTimeout, wDataQ, wStrbQ);
        OFS_MSG_RETRY:    msgRetry <= merge(msgRetry, wDataQ, wStrbQ);
        OFS_MSG_DEST_IP:  msgChanDestIp <= merge(msgChanDestIp, wDataQ, wStrbQ);
        OFS_MSG_HOST_PRT: msgChanHostPort <= wStrbQ[1:0] == 2'h3 ? wDataQ[15:0] : msgChanHostPort;
        OFS_STR_DEST_IP:  streamDestIp <= merge(streamDestIp, wDataQ, wStrbQ);
        OFS_STR_HOST_PRT: streamHostPort <= wStrbQ[1:0] == 2'h3 ? wDataQ[15:0] : streamHostPort;
        OFS_STR_PKT: begin
          if (candPkt >= PKT_MIN && candPkt <= PKT_MAX) begin
            streamPacketBytes <= candPkt[15:0];
          end
        end
        OFS_PKT_GAP:      pktGap <= merge(pktGap, wDataQ, wStrbQ);
        OFS_FRM_GAP:      frmGap <= merge(frmGap, wDataQ, wStrbQ);
        OFS_PRIV: begin
          // undefined code 3 is dropped so the field stays one of three levels
          if (candPriv <= 32'(SHARED_CONTROL_LEVEL)) begin
            controlPrivilege <= candPriv[1:0];
          end
        end
        OFS_STORED_IP:    storedIp <= merge(storedIp, wDataQ, wStrbQ);
        OFS_STORED_MASK:  storedMask <= merge(storedMask, wDataQ, wStrbQ);
        OFS_STORED_GW:    storedGw <= merge(storedGw, wDataQ, wStrbQ);
        default: ;
      endcase
    end
  end

  // timestamp prescaler and ms tick
  assign tsTick = tsPre == 16'(TS_DIV - 1);
  assign msTick = msPre == 32'(MS_CYC - 1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tsPre <= 16'h0000;
      msPre <= 32'h0000_0000;
    end else begin
      tsPre <= tsTick ? 16'h0000 : tsPre + 16'h0001;
      msPre <= msTick ? 32'h0000_0000 : msPre + 32'h0000_0001;
    end
  end

  // timestamp counter; clear wins over a tick in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tsCount <= 64'h0;
      tsSnap  <= 64'h0;
    end else begin
      if (wrFire && awAddrQ == OFS_TS_CLEAR) begin
        tsCount <= 64'h0;
      end else if (tsTick) begin
        tsCount <= tsCount + 64'h1;
      end
      if (wrFire && awAddrQ == OFS_TS_LATCH) begin
        tsSnap <= tsCount;
      end
    end
  end

  // controller record and keepalive supervision
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlPort       <= 16'h0000;
      ctrlIp         <= 32'h0000_0000;
      ctrlActive     <= 1'b0;
      kaCount        <= 32'h0000_0000;
      keepaliveLapse <= 1'b0;
    end else begin
      keepaliveLapse <= 1'b0;
      if (ctrlOpen) begin
        ctrlPort   <= ctrlPortIn;
        ctrlIp     <= ctrlIpIn;
        ctrlActive <= 1'b1;
        kaCount    <= 32'h0000_0000;
      end else if (heartbeatSeen || keepaliveOff) begin
        kaCount <= 32'h0000_0000;
      end else if (ctrlActive && msTick) begin
        if (kaCount >= kaTimeout) begin
          // lost controller: forget it so another host can take over
          keepaliveLapse <= 1'b1;
          ctrlActive     <= 1'b0;
          ctrlPort       <= 16'h0000;
          ctrlIp         <= 32'h0000_0000;
        end else begin
          kaCount <= kaCount + 32'h0000_0001;
        end
      end
    end
  end

  // random reply delay, scaled so it never exceeds the max
  assign discProd = lfsr * discMax[10:0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr            <= LFSR_SEED;
      discBusy        <= 1'b0;
      discCount       <= 32'h0000_0000;
      discoverReplyGo <= 1'b0;
    end else begin
      lfsr            <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      discoverReplyGo <= 1'b0;
      if (discoverReq && !discBusy) begin
        discBusy  <= 1'b1;
        discCount <= {21'h0, discProd[26:16]};
      end else if (discBusy && msTick) begin
        if (discCount == 32'h0000_0000) begin
          discBusy        <= 1'b0;
          discoverReplyGo <= 1'b1;
        end else begin
          discCount <= discCount - 32'h0000_0001;
        end
      end
    end
  end

  // message ack wait and retries
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msgState  <= MSG_IDLE;
      msgTimer  <= 32'h0000_0000;
      msgTries  <= 32'h0000_0000;
      msgResend <= 1'b0;
      msgGiveUp <= 1'b0;
    end else begin
      msgResend <= 1'b0;
      msgGiveUp <= 1'b0;
      case (msgState)
        MSG_IDLE: begin
          if (msgSent) begin
            msgState <= MSG_WAIT;
            msgTimer <= 32'h0000_0000;
            msgTries <= 32'h0000_0000;
          end
        end
        MSG_WAIT: begin
          if (msgAck) begin
            msgState <= MSG_IDLE;
          end else if (msTick) begin
            if (msgTimer < msgTimeout) begin
              msgTimer <= msgTimer + 32'h0000_0001;
            end else if (msgTries < msgRetry) begin
              msgResend <= 1'b1;
              msgTries  <= msgTries + 32'h0000_0001;
              msgTimer  <= 32'h0000_0000;
            end else begin
              msgGiveUp <= 1'b1;
              msgState  <= MSG_IDLE;
            end
          end
        end
        default: msgState <= MSG_IDLE;
      endcase
    end
  end

  // stream pacing: frame gap stacks on the packet gap, in clk cycles
  always_comb begin
    next_gapCount = gapCount;
    if (frameDone) begin
      next_gapCount = {1'b0, pktGap} + {1'b0, frmGap};
    end else if (pktDone) begin
      next_gapCount = {1'b0, pktGap};
    end else if (gapCount != 33'h0) begin
      next_gapCount = gapCount - 33'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapCount   <= 33'h0;
      streamHold <= 1'b0;
    end else begin
      gapCount   <= next_gapCount;
      streamHold <= next_gapCount != 33'h0;
    end
  end

  // read mux; reads have no side effects
  always_comb begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_CTRL:         rdMux = {25'h0, storedCfgEn, dynamicCfgEn, linkLocalCfgEn,
                                 streamPixelMsbFirst, streamNoFrag, streamProbePacketEn, keepaliveOff};
      OFS_TS_SNAP_LO:   rdMux = tsSnap[31:0];
      OFS_TS_SNAP_HI:   rdMux = tsSnap[63:32];
      OFS_TS_RATE:      rdMux = TS_RATE_HZ;
      OFS_KA_TMO:       rdMux = kaTimeout;
      OFS_DISC_MAX:     rdMux = discMax;
      OFS_MSG_TMO:      rdMux = msgTimeout;
      OFS_MSG_RETRY:    rdMux = msgRetry;
      OFS_MSG_DEST_IP:  rdMux = msgChanDestIp;
      OFS_MSG_HOST_PRT: rdMux = {16'h0000, msgChanHostPort};
      OFS_MSG_SRC_PRT:  rdMux = {16'h0000, MSG_SRC_PORT};
      OFS_STR_DEST_IP:  rdMux = streamDestIp;
      OFS_STR_HOST_PRT: rdMux = {16'h0000, streamHostPort};
      OFS_STR_SRC_PRT:  rdMux = {16'h0000, STR_SRC_PORT};
      OFS_STR_PKT:      rdMux = {16'h0000, streamPacketBytes};
      OFS_PKT_GAP:      rdMux = pktGap;
      OFS_FRM_GAP:      rdMux = frmGap;
      OFS_PRIV:         rdMux = {30'h0, controlPrivilege};
      OFS_CTL_PORT:     rdMux = {16'h0000, ctrlPort};
      OFS_CTL_IP:       rdMux = ctrlIp;
      OFS_STORED_IP:    rdMux = storedIp;
      OFS_STORED_MASK:  rdMux = storedMask;
      OFS_STORED_GW:    rdMux = storedGw;
      OFS_CUR_IP:       rdMux = curIp;
      OFS_CUR_MASK:     rdMux = curMask;
      OFS_CUR_GW:       rdMux = curGw;
      OFS_IP_CFG_STATE: rdMux = ipCfgState;
      OFS_DEV_INFO:     rdMux = {IFC_NUM, STR_CHAN_NUM, MSG_CHAN_NUM, 7'h0, REGSPACE_MSB};
      OFS_PAYLOAD:      rdMux = imagePayloadBytes;
      OFS_LINK_RATE:    rdMux = negotiatedRate;
      OFS_HW_ADDR_LO:   rdMux = hwNetAddress[31:0];
      OFS_HW_ADDR_HI:   rdMux = {16'h0000, hwNetAddress[47:32]};
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  // read address and data channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ntc_top

// ---- verif/ntc_checker.sv ----
module ntc_checker (
  // bus handshakes
  input wire logic        clk, rst, s_axi_awready, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  // events and settings
  input wire logic        discoverReplyGo, msgResend, msgGiveUp,
  input wire logic [1:0]  controlPrivilege,
  input wire logic [15:0] streamPacketBytes
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_single: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  a_priv_legal: assert property (controlPrivilege != 2'h3)
    else $error("undefined privilege");
  a_pkt_range: assert property (streamPacketBytes inside {[16'h0048:16'h3fec]})
    else $error("packet size out of range");
  a_reply_pulse: assert property (discoverReplyGo |=> !discoverReplyGo)
    else $error("reply pulse too long");
  a_resend_alone: assert property (!(msgResend && msgGiveUp))
    else $error("resend and give-up together");
endmodule // ntc_checker

// ---- verif/ntc_host_model.sv ----
module ntc_host_model (
  // stimulus from bench and block
  input wire logic clk, ackOn, ackLate, msgSent,
  // acknowledge back to block
  output logic     msgAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] sentDly = 3'h0;
  // acks each message one or three cycles later when enabled
  always_ff @(posedge clk) sentDly <= {sentDly[1:0], msgSent & ackOn};
  assign msgAck = ackLate ? sentDly[2] : sentDly[0];
endmodule // ntc_host_model

// ---- verif/test_network_transport_control.sv ----
module test_network_transport_control;
  import ntc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, ctrlOpen = 0, heartbeatSeen = 0, discoverReq = 0, msgSent = 0, pktDone = 0;
  logic frameDone = 0, ackOn = 0, ackLate = 0, msgAck, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, keepaliveLapse, discoverReplyGo, msgResend, msgGiveUp, streamHold;
  logic streamProbePacketEn, streamNoFrag, streamPixelMsbFirst, linkLocalCfgEn, dynamicCfgEn, storedCfgEn;
  logic [1:0] s_axi_bresp, s_axi_rresp, controlPrivilege, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ofs[12];
  logic [15:0] ctrlPortIn = 0, msgChanHostPort, streamHostPort, streamPacketBytes;
  logic [31:0] s_axi_wdata = 0, ctrlIpIn = 0, curIp, curMask, curGw, ipCfgState, imagePayloadBytes, d, v;
  logic [31:0] negotiatedRate, s_axi_rdata, msgChanDestIp, streamDestIp, storedIp, storedMask, storedGw, ev[12];
  logic [31:0] pk[4] = '{32'h47, 32'h48, 32'h3fec, 32'h3fed}, pe[4] = '{32'h5dc, 32'h48, 32'h3fec, 32'h3fec};
  logic [7:0] wo[4] = '{OFS_KA_TMO, OFS_MSG_DEST_IP, OFS_STR_DEST_IP, OFS_STORED_IP};
  logic [47:0] hwNetAddress;
  int bad_count = 0, samples_checked = 0, c, g;
  integer seed = 32'he3abe9bb;
  ntc_top #(.MS_CYC(20)) i_ntc_top (.*);
  ntc_host_model i_ntc_host_model (.*);
  always #25 clk = ~clk;
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int n = 0;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, x, 3'b111};
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 0;
    if (n >= 50) begin bad_count++; print_verdict(); end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] e);
    int n = 0;
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    {x, e} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
    if (n >= 50) begin bad_count++; print_verdict(); end
  endtask
  // counts high cycles of two outputs, 1 ns after each edge
  task automatic tally(ref logic a, b, input int lim, output int ca, cb);
    {ca, cb} = 0;
    repeat (lim) begin
      #1;
      ca += (a === 1'b1);
      cb += (b === 1'b1);
      @(posedge clk);
    end
  endtask
  initial begin
    {curIp, curMask, curGw, ipCfgState} = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {imagePayloadBytes, negotiatedRate} = {$random(seed), $random(seed)};
    hwNetAddress = 48'({$random(seed), $random(seed)});
    ofs = '{OFS_KA_TMO, OFS_DISC_MAX, OFS_MSG_TMO, OFS_MSG_RETRY, OFS_STR_PKT, OFS_TS_RATE, OFS_PRIV,
            OFS_MSG_SRC_PRT, OFS_CUR_IP, OFS_IP_CFG_STATE, OFS_PAYLOAD, OFS_HW_ADDR_LO};
    ev = '{KA_TMO_RST, DISC_MAX_RST, MSG_TMO_RST, MSG_RETRY_RST, PKT_RST, TS_RATE_HZ, 32'h1, 32'hc000,
           curIp, ipCfgState, imagePayloadBytes, hwNetAddress[31:0]};
    repeat (6) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 12; i++) begin rd(ofs[i], d, r); chk(d, ev[i]); end
    rd(8'hfc, d, r);
    chk(r, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin v = $random(seed); wr(wo[i], v); rd(wo[i], d, r); chk(d, v); end
    chk(storedIp, v);
    wr(OFS_MSG_SRC_PRT, 32'h1234);
    chk(s_axi_bresp, RESP_OKAY);
    rd(OFS_MSG_SRC_PRT, d, r);
    chk(d, 32'hc000);
    for (int i = 0; i < 4; i++) begin wr(OFS_STR_PKT, pk[i]); chk(streamPacketBytes, pe[i]); end
    for (int i = 2; i < 5; i++) begin wr(OFS_PRIV, i % 4); chk(controlPrivilege, i == 4 ? 0 : 2); end
    wr(OFS_CTRL, 32'h7f);
    chk({storedCfgEn, dynamicCfgEn, linkLocalCfgEn, streamPixelMsbFirst, streamNoFrag, streamProbePacketEn}, 32'h3f);
    // one ms keepalive: silent while off, one lapse once on
    wr(OFS_KA_TMO, 32'h1);
    v = $random(seed);
    @(posedge clk) {ctrlOpen, ctrlPortIn} <= {1'b1, v[15:0]};
    @(posedge clk) ctrlOpen <= 0;
    rd(OFS_CTL_PORT, d, r);
    chk(d, {16'h0, v[15:0]});
    tally(keepaliveLapse, discoverReplyGo, 100, c, g);
    chk(c, 0);
    wr(OFS_CTRL, 32'h0);
    tally(keepaliveLapse, discoverReplyGo, 100, c, g);
    chk(c, 1);
    wr(OFS_DISC_MAX, 32'h0);
    wr(OFS_DISC_MAX, 32'h3e9);
    @(posedge clk) discoverReq <= 1;
    @(posedge clk) discoverReq <= 0;
    tally(discoverReplyGo, msgGiveUp, 60, c, g);
    chk(c, 1);
    wr(OFS_TS_CLEAR, 32'h0);
    repeat (200) @(posedge clk);
    wr(OFS_TS_LATCH, 32'h0);
    rd(OFS_TS_SNAP_LO, d, r);
    chk(d >= 9 && d <= 12, 1);
    rd(OFS_TS_SNAP_HI, d, r);
    chk(d, 0);
    // no ack with retries 0 and 2, then slow and prompt acks
    wr(OFS_MSG_TMO, 32'h1);
    for (int k = 0; k < 4; k++) begin
      {ackOn, ackLate} <= {k > 1, k == 2};
      wr(OFS_MSG_RETRY, k == 0 ? 0 : 2);
      @(posedge clk) msgSent <= 1;
      @(posedge clk) msgSent <= 0;
      tally(msgResend, msgGiveUp, 200, c, g);
      chk(c, (k == 1) ? 2 : 0);
      chk(g, k < 2);
    end
    wr(OFS_PKT_GAP, 32'h5);
    wr(OFS_FRM_GAP, 32'h3);
    @(posedge clk) pktDone <= 1;
    @(posedge clk) pktDone <= 0;
    tally(streamHold, msgGiveUp, 20, c, g);
    chk(c, 5);
    @(posedge clk) frameDone <= 1;
    @(posedge clk) frameDone <= 0;
    tally(streamHold, msgGiveUp, 20, c, g);
    chk(c, 8);
    print_verdict();
  end
endmodule // test_network_transport_control
bind ntc_top ntc_checker i_ntc_checker (.*);
